/* File: rtl/mas_defines.vh */
`ifndef MAS_DEFINES_VH
`define MAS_DEFINES_VH
// wishbone register byte offsets
`define MAS_REG_LATCH 8'h00
`define MAS_REG_MASK 8'h04
`define MAS_REG_MAP 8'h08
`define MAS_REG_LIVE 8'h0C
`define MAS_REG_IRQ_STAT 8'h10
`define MAS_REG_IRQ_MASK 8'h14
// condition bit positions
`define MAS_BIT_HIPWR 0
`define MAS_BIT_READY 1
`define MAS_BIT_FAULT 2
`define MAS_BIT_LOS 3
`define MAS_NUM_SRC 8
// alarm map: three 3-bit source selects
`define MAS_MAP_RESET 9'h088
`define MAS_MASK_RESET 8'hFF
// interrupt status bits
`define MAS_IRQ_SUMMARY 0
`define MAS_IRQ_MDIO_RD 1
// mdio frame fields
`define MAS_ST_C45 2'h0
`define MAS_OP_ADDR 2'h0
`define MAS_OP_WRITE 2'h1
`define MAS_OP_READ 2'h3
`define MAS_OP_RINC 2'h2
`define MAS_PREAMBLE_MIN 6'h20
// mdio register addresses (within any device)
`define MAS_MDIO_LATCH 16'h0000
`define MAS_MDIO_MASK 16'h0001
`define MAS_MDIO_MAP 16'h0002
`define MAS_MDIO_LIVE 16'h0003
// timing
`define MAS_MDC_MAX_HZ 4000000
`define MAS_CLK_HZ 40000000
`define MAS_MDC_MIN_CYC (`MAS_CLK_HZ / `MAS_MDC_MAX_HZ)
`endif

/* File: rtl/mas_sync2.v */
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// two flip-flop synchroniser, one per bit
// ****************************************
module mas_sync2 #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire clk_i,
  input wire rst_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= INIT;
      q_o <= INIT;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/mas_mdio_slave.v */
`timescale 1ns/10ps
`default_nettype none
`include "mas_defines.vh"
// ****************************************
// clause 45 management slave on sampled mdc
// ****************************************
module mas_mdio_slave (
  input wire clk_i,
  input wire rst_i,
  input wire mdc_i,
  input wire mdio_in_i,
  input wire [4:0] port_addr_i,
  output reg mdio_out_o,
  output reg mdio_oe_o,
  output reg wr_o,
  output reg rd_o,
  output reg [15:0] addr_o,
  output reg [15:0] wdata_o,
  input wire [15:0] rdata_i
);
  localparam S_PRE = 4'b0001;
  localparam S_HDR = 4'b0010;
  localparam S_TA = 4'b0100;
  localparam S_DATA = 4'b1000;
  wire mdc_s;
  wire mdio_s;
  reg mdc_d_reg;
  reg [3:0] state_reg;
  reg [5:0] cnt_reg;
  reg [13:0] hdr_reg;
  reg [15:0] sh_reg;
  reg hit_reg;
  reg [1:0] op_reg;
  wire rise = mdc_s & ~mdc_d_reg;
  wire fall = ~mdc_s & mdc_d_reg;
  wire [13:0] hdr_next = {hdr_reg[12:0], mdio_s};
  mas_sync2 #(.W(2), .INIT(2'b11)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({mdc_i, mdio_in_i}),
    .q_o({mdc_s, mdio_s})
  );
  always @(posedge clk_i) begin
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    if (rst_i) begin
      mdc_d_reg <= 1'b1;
      state_reg <= S_PRE;
      cnt_reg <= 6'h00;
      hdr_reg <= 14'h0000;
      sh_reg <= 16'h0000;
      hit_reg <= 1'b0;
      op_reg <= 2'h0;
      mdio_out_o <= 1'b1;
      mdio_oe_o <= 1'b0;
      addr_o <= 16'h0000;
      wdata_o <= 16'h0000;
    end else begin
      mdc_d_reg <= mdc_s;
      case (state_reg)
        S_PRE: begin
          mdio_oe_o <= 1'b0;
          if (rise) begin
            if (mdio_s) begin
              if (cnt_reg != 6'h3F) cnt_reg <= cnt_reg + 6'h01;
            end else begin
              if (cnt_reg >= `MAS_PREAMBLE_MIN) begin
                state_reg <= S_HDR;
                hdr_reg <= 14'h0000;
              end
              cnt_reg <= 6'h00;
            end
          end
        end
        S_HDR: begin
          // st(second bit), op, prtad, devad: 13 bits after first st bit
          if (rise) begin
            hdr_reg <= hdr_next;
            cnt_reg <= cnt_reg + 6'h01;
            if (cnt_reg == 6'h0C) begin
              op_reg <= hdr_next[11:10];
              hit_reg <= (hdr_next[12] == 1'b0) && (hdr_next[9:5] == port_addr_i);
              cnt_reg <= 6'h00;
              state_reg <= S_TA;
              // strobe now: data capture and clear-on-read fall on one edge
              if (hdr_next[11] && hdr_next[12] == 1'b0 && hdr_next[9:5] == port_addr_i)
                rd_o <= 1'b1;
            end
          end
        end
        S_TA: begin
          if (rd_o) sh_reg <= rdata_i;
          if (rise) begin
            cnt_reg <= cnt_reg + 6'h01;
            if (cnt_reg == 6'h01) begin
              cnt_reg <= 6'h00;
              state_reg <= S_DATA;
            end
          end
          // read: release during first ta bit, drive zero on second
          if (fall && hit_reg && op_reg[1] && cnt_reg == 6'h01) begin
            mdio_oe_o <= 1'b1;
            mdio_out_o <= 1'b0;
          end
        end
        S_DATA: begin
          if (hit_reg && op_reg[1] && fall) begin
            mdio_out_o <= sh_reg[15];
            sh_reg <= {sh_reg[14:0], 1'b0};
          end
          if (rise) begin
            if (!op_reg[1]) sh_reg <= {sh_reg[14:0], mdio_s};
            cnt_reg <= cnt_reg + 6'h01;
            if (cnt_reg == 6'h0F) begin
              cnt_reg <= 6'h00;
              state_reg <= S_PRE;
              if (hit_reg) begin
                case (op_reg)
                  `MAS_OP_ADDR: addr_o <= {sh_reg[14:0], mdio_s};
                  `MAS_OP_WRITE: begin
                    wdata_o <= {sh_reg[14:0], mdio_s};
                    wr_o <= 1'b1;
                  end
                  `MAS_OP_RINC: addr_o <= addr_o + 16'h0001;
                  default: addr_o <= addr_o;
                endcase
              end
            end
          end
        end
        default: state_reg <= S_PRE;
      endcase
      if (state_reg == S_PRE && fall) mdio_oe_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/mas_alarm_top.v */
`timescale 1ns/10ps
`default_nettype none
`include "mas_defines.vh"
module mas_alarm_top (
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire irq_o,
  // module condition inputs, from module logic on clk_i
  input wire high_power_reached_i,
  input wire unit_ready_flag_i,
  input wire unit_fault_flag_i,
  input wire light_below_threshold_i,
  input wire [3:0] aux_cond_i,
  input wire init_done_i,
  // alarm pins
  output reg remappable_alert_out_one_o,
  output reg remappable_alert_out_two_o,
  output reg remappable_alert_out_three_o,
  output reg receive_light_lost_o,
  output wire unit_missing_strap_o,
  output wire summary_alert_low_o,
  output reg summary_alert_low_oe_o,
  // management pins
  input wire mdc_i,
  input wire mdio_i,
  output wire mdio_o,
  output wire mdio_oe_o,
  input wire port_addr_bit0_i,
  input wire port_addr_bit1_i,
  input wire port_addr_bit2_i,
  input wire port_addr_bit3_i,
  input wire port_addr_bit4_i
);
  // ****************************************
  // condition sources and synchronisers
  // ****************************************
  wire [4:0] port_addr_s;
  wire [7:0] live_cond;
  reg [7:0] latched_condition_set_reg;
  reg [7:0] mask_reg;
  reg [8:0] map_reg;
  reg [7:0] live_d_reg;
  reg [1:0] irq_stat_reg;
  reg [1:0] irq_mask_reg;
  reg summary_d_reg;
  wire m_wr;
  wire m_rd;
  wire [15:0] m_addr;
  wire [15:0] m_wdata;
  reg [15:0] m_rdata;
  wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_hit & wb_we_i & wb_sel_i[0];
  wire wb_rd = wb_hit & ~wb_we_i;
  wire latch_rd = (wb_rd && wb_adr_i == `MAS_REG_LATCH) ||
    (m_rd && m_addr == `MAS_MDIO_LATCH);
  wire summary;

  mas_sync2 #(.W(5), .INIT(5'h00)) u_padr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({port_addr_bit4_i, port_addr_bit3_i, port_addr_bit2_i, port_addr_bit1_i,
      port_addr_bit0_i}),
    .q_o(port_addr_s)
  );

  assign live_cond = {aux_cond_i, light_below_threshold_i, unit_fault_flag_i,
    unit_ready_flag_i, high_power_reached_i};

  // ****************************************
  // latched conditions, mask, summary alert
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      latched_condition_set_reg <= 8'h00;
      live_d_reg <= 8'h00;
    end else begin
      live_d_reg <= live_cond;
      // new rising event wins over a clearing read
      latched_condition_set_reg <= (latch_rd ? 8'h00 : latched_condition_set_reg)
        | (live_cond & ~live_d_reg);
    end
  end

  assign summary = |(latched_condition_set_reg & mask_reg);
  // open drain: data is always low, enable pulls the line
  assign summary_alert_low_o = 1'b0;
  assign unit_missing_strap_o = 1'b0;

  // ****************************************
  // alarm pin outputs
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      remappable_alert_out_one_o <= 1'b0;
      remappable_alert_out_two_o <= 1'b0;
      remappable_alert_out_three_o <= 1'b0;
      receive_light_lost_o <= 1'b0;
      summary_alert_low_oe_o <= 1'b0;
    end else if (!init_done_i) begin
      remappable_alert_out_one_o <= 1'b0;
      remappable_alert_out_two_o <= 1'b0;
      // pin three's mapped source (fault with the reset map) is reported even while initializing
      remappable_alert_out_three_o <= live_cond[map_reg[8:6]];
      receive_light_lost_o <= 1'b0;
      summary_alert_low_oe_o <= 1'b0;
    end else begin
      remappable_alert_out_one_o <= live_cond[map_reg[2:0]];
      remappable_alert_out_two_o <= live_cond[map_reg[5:3]];
      remappable_alert_out_three_o <= live_cond[map_reg[8:6]];
      receive_light_lost_o <= light_below_threshold_i;
      summary_alert_low_oe_o <= summary;
    end
  end

  // ****************************************
  // configuration writes from either bus; irq mask from wishbone only
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      mask_reg <= `MAS_MASK_RESET;
      map_reg <= `MAS_MAP_RESET;
      irq_mask_reg <= 2'b00;
    end else begin
      if (wb_wr && wb_adr_i == `MAS_REG_MASK) mask_reg <= wb_dat_i[7:0];
      if (wb_wr && wb_adr_i == `MAS_REG_MAP) map_reg <= wb_dat_i[8:0];
      if (wb_wr && wb_adr_i == `MAS_REG_IRQ_MASK) irq_mask_reg <= wb_dat_i[1:0];
      if (m_wr && m_addr == `MAS_MDIO_MASK) mask_reg <= m_wdata[7:0];
      if (m_wr && m_addr == `MAS_MDIO_MAP) map_reg <= m_wdata[8:0];
    end
  end

  // ****************************************
  // interrupt status, write one to clear
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= 2'b00;
      summary_d_reg <= 1'b0;
    end else begin
      summary_d_reg <= summary;
      irq_stat_reg <= (irq_stat_reg &
        ~((wb_wr && wb_adr_i == `MAS_REG_IRQ_STAT) ? wb_dat_i[1:0] : 2'b00))
        | {m_rd | m_wr, summary & ~summary_d_reg};
    end
  end
  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // ****************************************
  // wishbone slave, ack one cycle after request
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_rd) begin
        case (wb_adr_i)
          `MAS_REG_LATCH: wb_dat_o <= {24'h000000, latched_condition_set_reg};
          `MAS_REG_MASK: wb_dat_o <= {24'h000000, mask_reg};
          `MAS_REG_MAP: wb_dat_o <= {23'h000000, map_reg};
          `MAS_REG_LIVE: wb_dat_o <= {24'h000000, live_cond};
          `MAS_REG_IRQ_STAT: wb_dat_o <= {30'h00000000, irq_stat_reg};
          `MAS_REG_IRQ_MASK: wb_dat_o <= {30'h00000000, irq_mask_reg};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************
  // management slave and its read mux
  // ****************************************
  always @* begin
    case (m_addr)
      `MAS_MDIO_LATCH: m_rdata = {8'h00, latched_condition_set_reg};
      `MAS_MDIO_MASK: m_rdata = {8'h00, mask_reg};
      `MAS_MDIO_MAP: m_rdata = {7'h00, map_reg};
      `MAS_MDIO_LIVE: m_rdata = {8'h00, live_cond};
      default: m_rdata = 16'h0000;
    endcase
  end

  mas_mdio_slave u_mdio (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mdc_i(mdc_i),
    .mdio_in_i(mdio_i),
    .port_addr_i(port_addr_s),
    .mdio_out_o(mdio_o),
    .mdio_oe_o(mdio_oe_o),
    .wr_o(m_wr),
    .rd_o(m_rd),
    .addr_o(m_addr),
    .wdata_o(m_wdata),
    .rdata_i(m_rdata)
  );
endmodule
`default_nettype wire

/* File: bench/mas_alarm_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module mas_alarm_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic init_done_i,
  input wire logic unit_fault_flag_i,
  input wire logic light_below_threshold_i,
  input wire logic mdc_i,
  input wire logic remappable_alert_out_three_o,
  input wire logic receive_light_lost_o,
  input wire logic unit_missing_strap_o,
  input wire logic summary_alert_low_o,
  input wire logic summary_alert_low_oe_o,
  input wire logic mdio_oe_o,
  input wire logic irq_o
);
  // ****************
  // idle mdc counter
  // ****************
  logic [4:0] idle_reg;
  logic mdc_d_reg;
  always_ff @(posedge clk_i) begin
    mdc_d_reg <= mdc_i;
    if (rst_i || mdc_i != mdc_d_reg) idle_reg <= 5'h00;
    else if (idle_reg != 5'h1F) idle_reg <= idle_reg + 5'h01;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_strap_low: assert property (unit_missing_strap_o == 1'b0)
    else $error("absence strap not low");
  a_alert_od: assert property (summary_alert_low_o == 1'b0)
    else $error("summary alert drives high");
  a_los_high: assert property ((init_done_i && light_below_threshold_i)[*3] |->
    receive_light_lost_o)
    else $error("loss of light not shown");
  a_los_low: assert property ((!light_below_threshold_i)[*3] |-> !receive_light_lost_o)
    else $error("loss of light without cause");
  a_init_hold: assert property ((!init_done_i)[*3] |->
    !receive_light_lost_o && !summary_alert_low_oe_o)
    else $error("pin active before init");
  a_fault_init: assert property ((!init_done_i && unit_fault_flag_i)[*3] |->
    remappable_alert_out_three_o)
    else $error("fault pin idle during init");
  a_fault_alert: assert property (init_done_i && $rose(unit_fault_flag_i) |->
    ##[1:4] summary_alert_low_oe_o)
    else $error("summary alert missed a fault");
  // no bus read in flight on either bus: wishbone idle, management clock idle
  a_alert_sticky: assert property (summary_alert_low_oe_o && init_done_i && idle_reg[4] &&
    !wb_cyc_i && !$past(wb_cyc_i) && !$past(wb_cyc_i, 2) |=>
    summary_alert_low_oe_o || !init_done_i)
    else $error("summary alert released without read");
  a_mdio_idle: assert property (idle_reg[4] |-> !mdio_oe_o)
    else $error("data line driven outside frame");
  c_alert: cover property ($rose(summary_alert_low_oe_o));
  c_mdio: cover property ($rose(mdio_oe_o));
  c_irq: cover property ($rose(irq_o));
endmodule
bind mas_alarm_top mas_alarm_asserts u_mas_alarm_asserts (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .init_done_i(init_done_i), .unit_fault_flag_i(unit_fault_flag_i),
  .light_below_threshold_i(light_below_threshold_i), .mdc_i(mdc_i),
  .remappable_alert_out_three_o(remappable_alert_out_three_o),
  .receive_light_lost_o(receive_light_lost_o), .unit_missing_strap_o(unit_missing_strap_o),
  .summary_alert_low_o(summary_alert_low_o), .summary_alert_low_oe_o(summary_alert_low_oe_o),
  .mdio_oe_o(mdio_oe_o), .irq_o(irq_o));
`default_nettype wire

/* File: bench/mas_mdio_host.sv */
`timescale 1ns/10ps
`default_nettype none
module mas_mdio_host (
  input wire logic clk_i,
  input wire logic mdio_i,
  output logic mdc_o,
  output logic mdio_o,
  output logic oe_o
);
  initial begin
    mdc_o = 1'b1;
    mdio_o = 1'b1;
    oe_o = 1'b0;
  end
  // one bit: 8 clocks, 200 ns; sample at the rising mdc edge
  task automatic bit_cyc(input logic d, input logic drv, output logic s);
    @(posedge clk_i);
    mdc_o <= 1'b0;
    mdio_o <= drv ? d : ~d;
    oe_o <= drv;
    repeat (4) @(posedge clk_i);
    mdc_o <= 1'b1;
    s = mdio_i;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [15:0] d,
                       output logic [15:0] q);
    logic [63:0] f;
    logic s;
    integer i;
    f = {32'hFFFFFFFF, 2'h0, op, pa, 5'h01, 2'h2, d};
    for (i = 63; i >= 0; i--) begin
      bit_cyc(f[i], !(op[1] && i < 18), s);
      if (i < 16) q[i] = s;
    end
    bit_cyc(1'b1, 1'b0, s);
    // clock stands still high between frames, as with the line's pull-up
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* File: bench/mas_alarm_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module mas_alarm_top_tb;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, init_done_i;
  logic [7:0] wb_adr_i, cond;
  logic [31:0] wb_dat_i, q;
  logic [15:0] r;
  logic [4:0] pa;
  logic [8:0] m;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, irq_o, p1, p2, p3, los_o, strap_o, sal_o, sal_oe, mdc, d_out, d_oe, h_out, h_oe;
  wire mdio = d_oe ? d_out : (h_oe ? h_out : 1'b1);
  wire alert_pin = sal_oe ? sal_o : 1'b1;
  integer seed = 32'h2bf7, fail_count = 0, compares = 0, oe_seen = 0, i;
  mas_alarm_top u_mas_alarm_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .high_power_reached_i(cond[0]), .unit_ready_flag_i(cond[1]), .unit_fault_flag_i(cond[2]),
    .light_below_threshold_i(cond[3]), .aux_cond_i(cond[7:4]), .init_done_i(init_done_i),
    .remappable_alert_out_one_o(p1), .remappable_alert_out_two_o(p2),
    .remappable_alert_out_three_o(p3), .receive_light_lost_o(los_o),
    .unit_missing_strap_o(strap_o), .summary_alert_low_o(sal_o), .summary_alert_low_oe_o(sal_oe),
    .mdc_i(mdc), .mdio_i(mdio), .mdio_o(d_out), .mdio_oe_o(d_oe), .port_addr_bit0_i(pa[0]),
    .port_addr_bit1_i(pa[1]), .port_addr_bit2_i(pa[2]), .port_addr_bit3_i(pa[3]),
    .port_addr_bit4_i(pa[4]));
  mas_mdio_host u_host (.clk_i(clk_i), .mdio_i(mdio), .mdc_o(mdc), .mdio_o(h_out), .oe_o(h_oe));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (d_oe === 1'b1) oe_seen <= oe_seen + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("fail_count %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] rd);
    integer n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    chk(n, 2); // ack is registered: it answers on the second edge
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic set_c(input logic [7:0] v);
    cond <= v;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic pulse;
    cond <= 8'h10;
    @(posedge clk_i);
    set_c(8'h00);
  endtask
  initial begin
    #1000000;
    $display("unexpected at %0t: timeout", $time);
    fail_count++;
    summarize;
  end
  initial begin
    rst_i = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_adr_i = 8'h00;
    wb_dat_i = 32'h0; init_done_i = 1'b0; cond = 8'h00;
    pa = $random(seed);
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    set_c(8'h0F);
    chk(p3, 1);
    chk({p1, p2, los_o, sal_oe}, 0);
    chk(strap_o, 0);
    init_done_i <= 1'b1;
    wb(0, 8'h04, 0, q); chk(q, 32'hFF);
    wb(0, 8'h08, 0, q); chk(q, 32'h88);
    wb(0, 8'hFC, 0, q); chk(q, 0);
    for (i = 0; i < 16; i++) begin
      m = (i < 8) ? 9'h088 : {3'(i + 2), 3'(i + 1), 3'(i)};
      wb(1, 8'h08, {23'h0, m}, q);
      set_c($random(seed));
      chk({p1, p2, p3, los_o}, {cond[m[2:0]], cond[m[5:3]], cond[m[8:6]], cond[3]});
      wb(0, 8'h0C, 0, q); chk(q, {24'h0, cond});
    end
    wb(1, 8'h08, 32'h88, q);
    set_c(8'h00);
    wb(1, 8'h14, 1, q);
    wb(0, 8'h00, 0, q);
    wb(1, 8'h10, 3, q);
    repeat (4) @(posedge clk_i);
    chk({sal_oe, irq_o}, 0);
    pulse;
    chk({alert_pin, irq_o}, 2'h1);
    wb(0, 8'h00, 0, q); chk(q, 32'h10);
    repeat (4) @(posedge clk_i);
    chk(alert_pin, 1);
    wb(1, 8'h10, 1, q); chk(irq_o, 0);
    wb(1, 8'h04, 32'hEF, q);
    pulse;
    chk(sal_oe, 0);
    wb(0, 8'h00, 0, q); chk(q, 32'h10);
    wb(1, 8'h04, 32'hFF, q);
    wb(1, 8'h14, 2, q);
    set_c(8'hA5);
    oe_seen = 0;
    u_host.frame(2'h0, pa ^ 5'h01, 16'h0003, r);
    u_host.frame(2'h3, pa ^ 5'h01, 16'h0000, r);
    chk(oe_seen, 0); chk(irq_o, 0);
    u_host.frame(2'h0, pa, 16'h0003, r);
    u_host.frame(2'h3, pa, 16'h0000, r);
    chk(r, 16'h00A5); chk(irq_o, 1);
    u_host.frame(2'h0, pa, 16'h0002, r);
    u_host.frame(2'h1, pa, 16'h00D1, r);
    repeat (4) @(posedge clk_i);
    wb(0, 8'h08, 0, q); chk(q, 32'hD1);
    chk({p1, p2, p3}, 3'b010);
    u_host.frame(2'h0, pa, 16'h0000, r);
    u_host.frame(2'h2, pa, 16'h0000, r);
    chk(r, 16'h00A5);
    chk(alert_pin, 1);
    u_host.frame(2'h3, pa, 16'h0000, r);
    chk(r, 16'h00FF);
    wb(1, 8'h08, 32'h88, q);
    wb(1, 8'h10, 2, q); chk(irq_o, 0);
    summarize;
  end
endmodule
`default_nettype wire
